/* File: shared/lrr_pkg.sv */
//------------------------------------------------------------
// Overview of operation
// - pointer clear bit zeroes address, then self-clears
// - address clear never fetches byte zero itself
// - fetch bit reads addressed byte, self-clears
// - fetched byte lands in read-data field
// - option image pointer reads zero by default
// - pointer loaded from fixed EEPROM word location
// - pointer valid only above threshold value
// - reserved bits always read as zero
// - dual-phase limit fields always read zero
// - physical reply unit retries up to limit
// - async reply unit retries up to limit
// - async request unit retries up to limit
// - swap new-value register holds value to store, then old resource value after swap
// - swap expected register holds comparison value
// - detect EEPROM, set present, load info block
// - selector picks resource; done set, write clears
//------------------------------------------------------------
package lrr_pkg;

  //------------------------------------------------------------
  // register map (byte addresses)
  //------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFF_ROM_ACCESS = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_RETRY_LIMITS = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_SWAP_NEW = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_SWAP_EXPECTED = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_SWAP_CONTROL = 8'h14;

  //------------------------------------------------------------
  // field positions
  //------------------------------------------------------------
  localparam int BIT_PTR_CLEAR = 31;
  localparam int BIT_BYTE_FETCH = 25;
  localparam int LSB_BYTE_VALUE = 16;
  localparam int LSB_OPT_PTR = 0;
  localparam int LSB_PHYS_RETRY = 8;
  localparam int LSB_REPLY_RETRY = 4;
  localparam int LSB_REQUEST_RETRY = 0;
  localparam int BIT_SWAP_DONE = 31;
  localparam int LSB_SWAP_SEL = 0;
  localparam int RETRY_W = 4;
  localparam int NUM_UNITS = 3;
  localparam int UNIT_REQUEST = 0;
  localparam int UNIT_REPLY = 1;
  localparam int UNIT_PHYS = 2;

  //------------------------------------------------------------
  // values
  //------------------------------------------------------------
  localparam logic [7:0] OPT_PTR_WORD = 8'h28;
  localparam logic [7:0] OPT_PTR_MIN = 8'h39;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] BYTE_STEP = 8'h01;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
  localparam logic [RETRY_W-1:0] RETRY_ZERO = 4'h0;
  localparam logic [RETRY_W-1:0] RETRY_STEP = 4'h1;

  typedef enum logic [1:0] {
    LRR_SEL_BUS_MANAGER = 2'b00,
    LRR_SEL_BANDWIDTH = 2'b01,
    LRR_SEL_CHANNELS_HI = 2'b10,
    LRR_SEL_CHANNELS_LO = 2'b11
  } lrr_swap_sel_t;

  typedef enum logic [2:0] {
    LRR_ROM_IDLE = 3'b001,
    LRR_ROM_BOOT = 3'b010,
    LRR_ROM_READ = 3'b100
  } lrr_rom_state_t;

endpackage : lrr_pkg

/* File: design/lrr_retry_unit.sv */
`timescale 1ns/1ps
module lrr_retry_unit (
  input wire logic clk, // controller clock
  input wire logic reset, // synchronous, active high
  input wire logic [lrr_pkg::RETRY_W-1:0] limit, // retries allowed per packet
  input wire logic pkt_start, // new packet begins, pulse
  input wire logic ack_retryable, // busy or data-error ack, pulse
  output logic retry_go, // resend now, pulse
  output logic give_up, // limit spent, pulse
  output logic [lrr_pkg::RETRY_W-1:0] tries // retries spent on this packet
);

  typedef struct packed {
    logic [lrr_pkg::RETRY_W-1:0] count;
    logic go;
    logic fail;
  } lrr_retry_state_t;

  lrr_retry_state_t q_r;
  lrr_retry_state_t q_nxt;

  //------------------------------------------------------------
  // per-packet retry counter
  //------------------------------------------------------------
  always_comb begin
    q_nxt = q_r;
    q_nxt.go = 1'b0;
    q_nxt.fail = 1'b0;
    if (pkt_start) begin
      q_nxt.count = lrr_pkg::RETRY_ZERO;
    end else if (ack_retryable) begin
      // a limit of zero fails on the first bad ack
      if (q_r.count < limit) begin
        q_nxt.count = q_r.count + lrr_pkg::RETRY_STEP;
        q_nxt.go = 1'b1;
      end else begin
        q_nxt.fail = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign retry_go = q_r.go;
  assign give_up = q_r.fail;
  assign tries = q_r.count;

endmodule : lrr_retry_unit

/* File: design/lrr_regs.sv */
// The APB slave port was decided locally.
`timescale 1ns/1ps
module lrr_regs (
  input wire logic clk, // controller clock, 20 MHz
  input wire logic reset, // synchronous, active high
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction, high for write
  input wire logic [lrr_pkg::ADDR_W-1:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  input wire logic eeprom_detect, // serial-bus logic found an eeprom
  output logic eeprom_present, // present flag for the version register
  output logic bib_load, // start of bus info block load, pulse
  output logic rom_req, // byte read request, held until ack
  output logic [7:0] rom_addr, // byte address of the request
  input wire logic rom_ack, // byte read finished, pulse
  input wire logic [7:0] rom_data, // byte read, valid with rom_ack
  output logic option_image_valid, // option image pointer is usable
  output logic [7:0] option_image_pointer, // pointer loaded at boot
  input wire logic [lrr_pkg::NUM_UNITS-1:0] pkt_start, // per unit: packet start
  input wire logic [lrr_pkg::NUM_UNITS-1:0] ack_retryable, // per unit: busy or error
  output logic [lrr_pkg::NUM_UNITS-1:0] retry_go, // per unit: resend pulse
  output logic [lrr_pkg::NUM_UNITS-1:0] give_up, // per unit: failure pulse
  output logic [31:0] bus_manager_id, // resource 00
  output logic [31:0] bandwidth_available, // resource 01
  output logic [31:0] channels_available_hi, // resource 10
  output logic [31:0] channels_available_lo // resource 11
);

  typedef struct packed {
    lrr_pkg::lrr_rom_state_t state;
    logic rom_pointer_clear;
    logic rom_byte_fetch;
    logic [7:0] rom_byte_value;
    logic [7:0] ptr;
    logic [7:0] bus_addr;
    logic req;
    logic boot_rd;
    logic [7:0] opt_ptr;
    logic present;
    logic bib;
    logic [lrr_pkg::RETRY_W-1:0] phys_reply_retry_max;
    logic [lrr_pkg::RETRY_W-1:0] async_reply_retry_max;
    logic [lrr_pkg::RETRY_W-1:0] async_request_retry_max;
    logic [31:0] swap_new;
    logic [31:0] swap_exp;
    logic [1:0] swap_target_select;
    logic swap_complete;
    logic swap_go;
    logic [3:0][31:0] res;
    logic [31:0] rdata;
  } lrr_regs_state_t;

  lrr_regs_state_t q_r;
  lrr_regs_state_t q_nxt;

  logic setup_rd;
  logic access_wr;
  logic [31:0] old_value;
  logic [lrr_pkg::NUM_UNITS-1:0][lrr_pkg::RETRY_W-1:0] unit_limit;

  //------------------------------------------------------------
  // address decode helpers
  //------------------------------------------------------------
  function automatic logic hit(input logic [lrr_pkg::ADDR_W-1:0] a,
                               input logic [lrr_pkg::ADDR_W-1:0] off);
    hit = (a == off);
  endfunction : hit

  function automatic logic mapped(input logic [lrr_pkg::ADDR_W-1:0] a);
    mapped = hit(a, lrr_pkg::OFF_ROM_ACCESS) || hit(a, lrr_pkg::OFF_RETRY_LIMITS) ||
             hit(a, lrr_pkg::OFF_SWAP_NEW) || hit(a, lrr_pkg::OFF_SWAP_EXPECTED) ||
             hit(a, lrr_pkg::OFF_SWAP_CONTROL);
  endfunction : mapped

  function automatic logic [31:0] readback(input lrr_regs_state_t s,
                                           input logic [lrr_pkg::ADDR_W-1:0] a);
    logic [31:0] v;
    v = lrr_pkg::WORD_ZERO;
    if (hit(a, lrr_pkg::OFF_ROM_ACCESS)) begin
      v[lrr_pkg::BIT_PTR_CLEAR] = s.rom_pointer_clear;
      v[lrr_pkg::BIT_BYTE_FETCH] = s.rom_byte_fetch;
      v[lrr_pkg::LSB_BYTE_VALUE +: 8] = s.rom_byte_value;
      v[lrr_pkg::LSB_OPT_PTR +: 8] = s.opt_ptr;
    end else if (hit(a, lrr_pkg::OFF_RETRY_LIMITS)) begin
      v[lrr_pkg::LSB_PHYS_RETRY +: lrr_pkg::RETRY_W] = s.phys_reply_retry_max;
      v[lrr_pkg::LSB_REPLY_RETRY +: lrr_pkg::RETRY_W] = s.async_reply_retry_max;
      v[lrr_pkg::LSB_REQUEST_RETRY +: lrr_pkg::RETRY_W] = s.async_request_retry_max;
    end else if (hit(a, lrr_pkg::OFF_SWAP_NEW)) begin
      v = s.swap_new;
    end else if (hit(a, lrr_pkg::OFF_SWAP_EXPECTED)) begin
      v = s.swap_exp;
    end else if (hit(a, lrr_pkg::OFF_SWAP_CONTROL)) begin
      v[lrr_pkg::BIT_SWAP_DONE] = s.swap_complete;
      v[lrr_pkg::LSB_SWAP_SEL +: 2] = s.swap_target_select;
    end
    readback = v;
  endfunction : readback

  //------------------------------------------------------------
  // apb handshake
  //------------------------------------------------------------
  // read data is captured in the setup cycle, so every access ends
  // after one access-phase cycle with no wait states
  assign setup_rd = psel && !penable && !pwrite;
  assign access_wr = psel && penable && pwrite && mapped(paddr);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped(paddr);
  assign old_value = q_r.res[q_r.swap_target_select];

  //------------------------------------------------------------
  // next state
  //------------------------------------------------------------
  always_comb begin
    q_nxt = q_r;
    q_nxt.bib = 1'b0;
    if (setup_rd) begin
      q_nxt.rdata = readback(q_r, paddr);
    end

    // eeprom byte engine; hardware clears come before software
    // sets below so a write landing on completion is not lost
    unique case (q_r.state)
      lrr_pkg::LRR_ROM_BOOT: begin
        // strap-like level is sampled one clock after reset release
        q_nxt.present = eeprom_detect;
        if (eeprom_detect) begin
          q_nxt.bib = 1'b1;
          q_nxt.bus_addr = lrr_pkg::OPT_PTR_WORD;
          q_nxt.req = 1'b1;
          q_nxt.boot_rd = 1'b1;
          q_nxt.state = lrr_pkg::LRR_ROM_READ;
        end else begin
          q_nxt.state = lrr_pkg::LRR_ROM_IDLE;
        end
      end
      lrr_pkg::LRR_ROM_IDLE: begin
        if (q_r.rom_pointer_clear) begin
          // no fetch follows; the byte field keeps its last value
          q_nxt.ptr = lrr_pkg::BYTE_ZERO;
          q_nxt.rom_pointer_clear = 1'b0;
        end else if (q_r.rom_byte_fetch) begin
          q_nxt.bus_addr = q_r.ptr;
          q_nxt.req = 1'b1;
          q_nxt.state = lrr_pkg::LRR_ROM_READ;
        end
      end
      lrr_pkg::LRR_ROM_READ: begin
        if (rom_ack) begin
          q_nxt.req = 1'b0;
          q_nxt.state = lrr_pkg::LRR_ROM_IDLE;
          if (q_r.boot_rd) begin
            q_nxt.opt_ptr = rom_data;
            q_nxt.boot_rd = 1'b0;
          end else begin
            q_nxt.rom_byte_value = rom_data;
            q_nxt.ptr = q_r.ptr + lrr_pkg::BYTE_STEP;
            q_nxt.rom_byte_fetch = 1'b0;
          end
        end
      end
      default: begin
        q_nxt.req = 1'b0;
        q_nxt.state = lrr_pkg::LRR_ROM_IDLE;
      end
    endcase

    // register writes
    if (access_wr) begin
      if (hit(paddr, lrr_pkg::OFF_ROM_ACCESS)) begin
        // writing zero never cancels a pending action
        if (pwdata[lrr_pkg::BIT_PTR_CLEAR]) begin
          q_nxt.rom_pointer_clear = 1'b1;
        end
        if (pwdata[lrr_pkg::BIT_BYTE_FETCH]) begin
          q_nxt.rom_byte_fetch = 1'b1;
        end
      end
      if (hit(paddr, lrr_pkg::OFF_RETRY_LIMITS)) begin
        q_nxt.phys_reply_retry_max =
          pwdata[lrr_pkg::LSB_PHYS_RETRY +: lrr_pkg::RETRY_W];
        q_nxt.async_reply_retry_max =
          pwdata[lrr_pkg::LSB_REPLY_RETRY +: lrr_pkg::RETRY_W];
        q_nxt.async_request_retry_max =
          pwdata[lrr_pkg::LSB_REQUEST_RETRY +: lrr_pkg::RETRY_W];
      end
      if (hit(paddr, lrr_pkg::OFF_SWAP_NEW)) begin
        q_nxt.swap_new = pwdata;
      end
      if (hit(paddr, lrr_pkg::OFF_SWAP_EXPECTED)) begin
        q_nxt.swap_exp = pwdata;
      end
      if (hit(paddr, lrr_pkg::OFF_SWAP_CONTROL)) begin
        q_nxt.swap_target_select = pwdata[lrr_pkg::LSB_SWAP_SEL +: 2];
        q_nxt.swap_complete = 1'b0;
        q_nxt.swap_go = 1'b1;
      end
    end

    // compare-swap runs the cycle after the control write
    if (q_r.swap_go) begin
      q_nxt.swap_go = 1'b0;
      if (old_value == q_r.swap_exp) begin
        q_nxt.res[q_r.swap_target_select] = q_r.swap_new;
      end
      q_nxt.swap_new = old_value;
      q_nxt.swap_complete = 1'b1;
    end
  end

  //------------------------------------------------------------
  // state register
  //------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      q_r <= '0;
      q_r.state <= lrr_pkg::LRR_ROM_BOOT;
      q_r.opt_ptr <= lrr_pkg::BYTE_ZERO;
    end else begin
      q_r <= q_nxt;
    end
  end

  //------------------------------------------------------------
  // retry units
  //------------------------------------------------------------
  assign unit_limit[lrr_pkg::UNIT_REQUEST] = q_r.async_request_retry_max;
  assign unit_limit[lrr_pkg::UNIT_REPLY] = q_r.async_reply_retry_max;
  assign unit_limit[lrr_pkg::UNIT_PHYS] = q_r.phys_reply_retry_max;

  genvar gi;
  generate
    for (gi = 0; gi < lrr_pkg::NUM_UNITS; gi++) begin : g_unit
      lrr_retry_unit u_retry (
        .clk(clk),
        .reset(reset),
        .limit(unit_limit[gi]),
        .pkt_start(pkt_start[gi]),
        .ack_retryable(ack_retryable[gi]),
        .retry_go(retry_go[gi]),
        .give_up(give_up[gi]),
        .tries()
      );
    end
  endgenerate

  //------------------------------------------------------------
  // outputs
  //------------------------------------------------------------
  assign prdata = q_r.rdata;
  assign eeprom_present = q_r.present;
  assign bib_load = q_r.bib;
  assign rom_req = q_r.req;
  assign rom_addr = q_r.bus_addr;
  assign option_image_pointer = q_r.opt_ptr;
  // a pointer at or below the threshold means no option image
  assign option_image_valid = (q_r.opt_ptr > lrr_pkg::OPT_PTR_MIN);
  assign bus_manager_id = q_r.res[lrr_pkg::LRR_SEL_BUS_MANAGER];
  assign bandwidth_available = q_r.res[lrr_pkg::LRR_SEL_BANDWIDTH];
  assign channels_available_hi = q_r.res[lrr_pkg::LRR_SEL_CHANNELS_HI];
  assign channels_available_lo = q_r.res[lrr_pkg::LRR_SEL_CHANNELS_LO];

endmodule : lrr_regs

/* File: sim/lrr_checker.sv */
`timescale 1ns/1ps
module lrr_checker (
  input wire logic clk, // clock
  input wire logic reset, // sync reset
  input wire logic psel, // apb select
  input wire logic penable, // apb access
  input wire logic pwrite, // apb write
  input wire logic [lrr_pkg::ADDR_W-1:0] paddr, // apb address
  input wire logic [31:0] pwdata, // apb data
  input wire logic bib_load, // boot load pulse
  input wire logic eeprom_present, // present flag
  input wire logic rom_req, // byte request
  input wire logic [7:0] rom_addr, // byte address
  input wire logic rom_ack, // byte done
  input wire logic option_image_valid, // pointer usable
  input wire logic [7:0] option_image_pointer, // loaded pointer
  input wire logic [lrr_pkg::NUM_UNITS-1:0] ack_retryable, // bad acks
  input wire logic [lrr_pkg::NUM_UNITS-1:0] retry_go, // resend
  input wire logic [lrr_pkg::NUM_UNITS-1:0] give_up // failure
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // a clear in the same word is served first, so only plain fetches count
  sequence s_fetch_wr;
    psel && penable && pwrite && paddr == 8'h04 && pwdata[25] && !pwdata[31] && !rom_req;
  endsequence
  sequence s_busy;
    rom_req && !rom_ack;
  endsequence
  // the fetch bit lands at the access edge and the engine raises the request one edge later
  property p_fetch; s_fetch_wr |=> ##1 rom_req; endproperty
  property p_hold; s_busy |=> rom_req && $stable(rom_addr); endproperty
  property p_drop; rom_req && rom_ack |=> !rom_req; endproperty
  property p_opt; option_image_valid == (option_image_pointer > 8'h39); endproperty
  property p_boot; bib_load |-> rom_req && rom_addr == 8'h28 && eeprom_present; endproperty
  property p_pulse; bib_load |=> !bib_load [*8]; endproperty
  property p_cause; ((retry_go | give_up) & ~$past(ack_retryable)) == 3'b000; endproperty
  property p_excl; (retry_go & give_up) == 3'b000; endproperty
  a_fetch: assert property (p_fetch) else $error("fetch raised no request");
  a_hold: assert property (p_hold) else $error("request dropped early");
  a_drop: assert property (p_drop) else $error("request held after ack");
  a_opt: assert property (p_opt) else $error("pointer valid flag wrong");
  a_boot: assert property (p_boot) else $error("boot read wrong");
  a_pulse: assert property (p_pulse) else $error("boot load repeated");
  a_cause: assert property (p_cause) else $error("retry outcome without ack");
  a_excl: assert property (p_excl) else $error("retry and give up together");
endmodule : lrr_checker

/* File: sim/lrr_eeprom_model.sv */
`timescale 1ns/1ps
module lrr_eeprom_model (
  input wire logic clk, // clock
  input wire logic reset, // sync reset
  input wire logic [3:0] lat, // answer delay in cycles
  input wire logic rom_req, // byte request
  input wire logic [7:0] rom_addr, // byte address
  output logic rom_ack, // byte done pulse
  output logic [7:0] rom_data // byte, valid with ack
);
  logic [3:0] cnt_r;
  // data toggles when not answering so a stale byte never passes for a good one
  always_ff @(posedge clk) begin
    rom_ack <= 1'b0;
    rom_data <= ~rom_data;
    if (reset || !rom_req || rom_ack) begin
      cnt_r <= 4'h0;
    end else if (cnt_r == lat) begin
      rom_ack <= 1'b1;
      rom_data <= rom_addr ^ 8'ha5;
    end else begin
      cnt_r <= cnt_r + 4'h1;
    end
    if (reset)
      rom_data <= 8'h00;
  end
endmodule : lrr_eeprom_model

/* File: sim/lrr_regs_tb.sv */
`timescale 1ns/1ps
module lrr_regs_tb;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, eeprom_detect = 1'b1;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, q, v;
  logic pready, pslverr, slv_err, eeprom_present, bib_load, rom_req, rom_ack;
  logic [7:0] rom_addr, rom_data, option_image_pointer;
  logic option_image_valid;
  logic [3:0] lat = 4'hf;
  logic [2:0] pkt_start = 3'b000, ack_retryable = 3'b000, retry_go, give_up;
  logic [31:0] res [4];
  int errors = 0, check_count = 0;
  always #25 clk = ~clk;
  lrr_regs u_dut (.clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .eeprom_detect, .eeprom_present, .bib_load, .rom_req, .rom_addr, .rom_ack,
    .rom_data, .option_image_valid, .option_image_pointer, .pkt_start, .ack_retryable,
    .retry_go, .give_up, .bus_manager_id(res[0]), .bandwidth_available(res[1]),
    .channels_available_hi(res[2]), .channels_available_lo(res[3]));
  lrr_eeprom_model u_rom (.clk, .reset, .lat, .rom_req, .rom_addr, .rom_ack, .rom_data);
  //------------------------------------------------------------
  // bus and check tasks
  //------------------------------------------------------------
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : cmp
  // an idle cycle follows each transfer so no signal is driven twice in one step
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // no cap on wait states: only the watchdog ends a hung access
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    q = prdata;
    slv_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
    apb(1'b0, a, 32'h0000_0000);
    cmp(q & m, exp);
  endtask : rd
  task automatic wait_rom();
    int n;
    n = 0;
    // the request rises on the edge after the write, so look from the next edge on
    do begin
      @(posedge clk);
      n++;
    end while (rom_req !== 1'b0 && n < 100);
    cmp(rom_req, 1'b0);
  endtask : wait_rom
  task automatic retry_try(input int u, input int lim);
    pkt_start <= 3'b001 << u;
    @(posedge clk);
    pkt_start <= 3'b000;
    for (int k = 0; k <= lim; k++) begin
      ack_retryable <= 3'b001 << u;
      @(posedge clk);
      ack_retryable <= 3'b000;
      #1;
      cmp({retry_go[u], give_up[u]}, {k < lim, k == lim});
      @(posedge clk);
    end
  endtask : retry_try
  task automatic finish_test();
    $display("checks %0d, mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : finish_test
  //------------------------------------------------------------
  // tests
  //------------------------------------------------------------
  initial begin
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    // slow boot answer lets the pointer be seen before it loads
    rd(8'h04, 32'h0000_0000, 32'hff00_ffff);
    rd(8'h08, 32'h0000_0000, 32'hffff_ffff);
    cmp(eeprom_present, 1'b1);
    wait_rom();
    cmp({option_image_valid, option_image_pointer}, 9'h18d);
    rd(8'h04, 32'h0000_008d, 32'hff00_ffff);
    $display("boot test done");
    lat <= 4'h3;
    apb(1'b0, 8'h04, 32'h0000_0000);
    v = q & 32'h00ff_00ff;
    apb(1'b1, 8'h04, 32'h8000_0000);
    rd(8'h04, v, 32'hffff_ffff);
    cmp(rom_req, 1'b0);
    for (int j = 0; j < 4; j++) begin
      if (j == 3) apb(1'b1, 8'h04, 32'h8000_0000);
      apb(1'b1, 8'h04, 32'h0200_0000);
      if (j == 0) rd(8'h04, 32'h0200_0000, 32'h0200_0000);
      wait_rom();
      rd(8'h04, {8'h00, 8'(j % 3) ^ 8'ha5, 16'h008d}, 32'hffff_ffff);
    end
    $display("eeprom test done");
    apb(1'b1, 8'h08, 32'hffff_ffff);
    rd(8'h08, 32'h0000_0fff, 32'hffff_ffff);
    apb(1'b1, 8'h08, 32'h0000_0213);
    retry_try(0, 3);
    retry_try(1, 1);
    retry_try(2, 2);
    apb(1'b1, 8'h08, 32'h0000_0000);
    retry_try(0, 0);
    $display("retry test done");
    for (int s = 0; s < 4; s++) begin
      apb(1'b1, 8'h0c, 32'h5a00_0000 + s);
      apb(1'b1, 8'h10, 32'h0000_0000);
      apb(1'b1, 8'h14, s);
      rd(8'h14, 32'h8000_0000 + s, 32'hffff_ffff);
      cmp(res[s], 32'h5a00_0000 + s);
      rd(8'h0c, 32'h0000_0000, 32'hffff_ffff);
    end
    apb(1'b1, 8'h10, 32'hdead_beef);
    apb(1'b1, 8'h0c, 32'h0000_1111);
    apb(1'b1, 8'h14, 32'h0000_0000);
    rd(8'h10, 32'hdead_beef, 32'hffff_ffff);
    cmp(res[0], 32'h5a00_0000);
    rd(8'h0c, 32'h5a00_0000, 32'hffff_ffff);
    rd(8'h40, 32'h0000_0000, 32'hffff_ffff);
    cmp(slv_err, 1'b1);
    $display("swap test done");
    // second reset with no eeprom fitted: nothing is loaded and the pointer stays unusable
    reset <= 1'b1;
    eeprom_detect <= 1'b0;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    repeat (2) @(posedge clk);
    cmp({eeprom_present, bib_load, rom_req, option_image_valid}, 4'h0);
    rd(8'h04, 32'h0000_0000, 32'hffff_ffff);
    $display("no eeprom test done");
    finish_test();
  end
  initial begin
    repeat (4000) @(posedge clk);
    errors++;
    $display("Error at %0t: watchdog expired", $time);
    finish_test();
  end
endmodule : lrr_regs_tb
bind lrr_regs lrr_checker u_chk (.clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata,
  .bib_load, .eeprom_present, .rom_req, .rom_addr, .rom_ack, .option_image_valid,
  .option_image_pointer, .ack_retryable, .retry_go, .give_up);
